// ==== fbp_pkg.sv ====
/*
 Package for the field bus channel poller: register map, field positions,
 reset values, timing constants and carrier structs.
 Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package fbp_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
   localparam logic [3:0] WAIT_CODE_RST = 4'h9;
   localparam logic [15:0] GAP_MS_RST = 16'h0000;
   localparam logic [2:0] OPCODE_OFF = 3'h0;
   localparam logic [2:0] OPCODE_BUS = 3'h4;
   localparam logic [7:0] TYPE_UNKNOWN = 8'hFF;
   // Error bitmap positions
   localparam int unsigned ERR_COMM = 1;
   localparam int unsigned ERR_UNKNOWN = 2;
   localparam int unsigned ERR_SELFTEST = 3;
   localparam int unsigned ERR_CALIB = 4;
   localparam int unsigned ERR_OFFLINE = 6;
   localparam int unsigned ERR_SENSOR = 9;
   localparam int unsigned ERR_PHASE = 10;
   localparam int unsigned ERR_PHSEQ = 11;
   localparam int unsigned ERR_OVFL = 12;
   localparam int unsigned ERR_PARAM = 25;
   localparam logic [31:0] ERR_REMOTE_MASK = 32'h00001E1C;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_GAP = 8'h04;
   localparam logic [7:0] REG_SEL = 8'h08;
   localparam logic [7:0] REG_CHCFG = 8'h0C;
   localparam logic [7:0] REG_NODE = 8'h10;
   localparam logic [7:0] REG_PARAM = 8'h14;
   localparam logic [7:0] REG_CHSTAT = 8'h18;
   localparam logic [7:0] REG_ERR = 8'h1C;
   localparam logic [7:0] REG_DELTA = 8'h20;
   localparam logic [7:0] REG_REINST = 8'h24;
   localparam logic [7:0] REG_IRQ_STAT = 8'h28;
   localparam logic [7:0] REG_IRQ_CLR = 8'h2C;
   localparam logic [7:0] REG_IRQ_EN = 8'h30;
   localparam int unsigned CFG_RUN = 3;
   localparam int unsigned CFG_PARAMS = 4;
   localparam int unsigned CFG_ENERGY = 5;
   localparam int unsigned REINST_ALL = 1;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_TIMEOUT = 1;
   localparam int unsigned IRQ_FAULT = 2;

   typedef enum logic [1:0] {
      FBP_Q_POLL,
      FBP_Q_SEARCH,
      FBP_Q_PWRITE,
      FBP_Q_PREAD
   } fbp_qkind_e;

   typedef struct packed {
      fbp_qkind_e kind;
      logic [5:0] chan;
      logic [31:0] node;
      logic [31:0] param;
   } fbp_query_s;

   typedef struct packed {
      logic [7:0] dev_type;
      logic [7:0] sub_count;
      logic [31:0] status;
      logic [31:0] value;
   } fbp_reply_s;

   // Wait table in ms per response-wait code
   function automatic logic [11:0] fbp_wait_ms(input logic [3:0] code);
      logic [11:0] base;
      base = code[0] ? 12'h003 : 12'h002;
      return 12'((base << (code >> 1)) << 3);
   endfunction : fbp_wait_ms
endpackage : fbp_pkg

// ==== fbp_poller.sv ====
/*
 Field bus channel poller: scans enabled channels round robin, issues
 queries, times out replies, installs channels, keeps error bitmaps.
 Assumes a transceiver that accepts one query when query_ready_i is high
 and returns at most one reply per query on reply_valid_i.
*/
`timescale 1ns/1ps
module fbp_poller
   import fbp_pkg::*;
#(
   parameter int unsigned NUM_CH = 64
) (
   input wire logic clk_i, // System clock
   input wire logic sys_rst_i, // Synchronous reset
   input wire logic hsel_i, // AHB select
   input wire logic [31:0] haddr_i, // AHB address
   input wire logic [1:0] htrans_i, // AHB transfer type
   input wire logic hwrite_i, // AHB write
   input wire logic [2:0] hsize_i, // AHB size
   input wire logic [31:0] hwdata_i, // AHB write data
   input wire logic hready_i, // AHB ready in
   output logic [31:0] hrdata_o, // AHB read data
   output logic hreadyout_o, // AHB ready out
   output logic hresp_o, // AHB response
   output fbp_query_s query_o, // Query to transceiver
   output logic query_valid_o, // Query strobe
   input wire logic query_ready_i, // Transceiver accepts
   input wire fbp_reply_s reply_i, // Reply from remote
   input wire logic reply_valid_i, // Reply strobe
   output logic irq_o // Interrupt level
);
   localparam int unsigned CW = $clog2(NUM_CH);
   if (NUM_CH < 2 || NUM_CH > 64 || (1 << CW) != NUM_CH) begin : g_bad_cfg
      $error("NUM_CH must be a power of two from 2 to 64");
   end

   typedef enum {S_PICK, S_SEND, S_WAIT, S_GAP} fbp_state_e;

   // Per-channel state
   logic [2:0] opcode_q [NUM_CH], opcode_d [NUM_CH];
   logic [5:0] cfg_q [NUM_CH], cfg_d [NUM_CH];
   logic [31:0] node_q [NUM_CH], node_d [NUM_CH];
   logic [31:0] param_q [NUM_CH], param_d [NUM_CH];
   logic [31:0] err_q [NUM_CH], err_d [NUM_CH];
   logic [7:0] type_q [NUM_CH], type_d [NUM_CH];
   logic [7:0] count_q [NUM_CH], count_d [NUM_CH];
   logic [31:0] prev_q [NUM_CH], prev_d [NUM_CH];
   logic [31:0] delta_q [NUM_CH], delta_d [NUM_CH];
   logic [NUM_CH-1:0] need_q, need_d, prim_q, prim_d, run_q, run_d;
   // Global state
   logic [3:0] wcode_q, wcode_d;
   logic [15:0] gap_q, gap_d;
   logic [CW-1:0] sel_q, sel_d, cur_q, cur_d;
   logic [2:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
   fbp_state_e st_q, st_d;
   fbp_qkind_e kind_q, kind_d;
   logic [31:0] tmr_q, tmr_d;
   logic [15:0] ms_q, ms_d;
   // Bus data phase
   logic wr_ph_q, wr_ph_d, rd_ph_q, rd_ph_d;
   logic [7:0] adr_q, adr_d;
   logic [31:0] rdata_q, rdata_d;

   logic [NUM_CH-1:0] elig;
   logic [CW-1:0] nxt;
   logic nxt_ok;
   logic [31:0] wait_cyc;
   logic [2:0] irq_ev;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_elig
      assign elig[g] = (opcode_q[g] == OPCODE_BUS) && cfg_q[g][CFG_RUN];
   end

   // Next eligible channel after the current one, wrapping
   always_comb begin
      logic [CW-1:0] idx;
      idx = '0;
      nxt = cur_q;
      nxt_ok = 1'b0;
      for (int k = NUM_CH; k >= 1; k--) begin
         idx = CW'((int'(cur_q) + k) % NUM_CH);
         if (elig[idx]) begin
            nxt = idx;
            nxt_ok = 1'b1;
         end
      end
   end

   assign wait_cyc = 32'(fbp_wait_ms(wcode_q)) * CYC_PER_MS;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = rdata_q;
   assign irq_o = |(irq_st_q & irq_en_q);
   assign query_valid_o = (st_q == S_SEND);
   always_comb begin
      query_o.kind = kind_q;
      query_o.chan = 6'(cur_q);
      query_o.node = node_q[cur_q];
      query_o.param = param_q[cur_q];
   end

   always_comb begin
      logic take;
      logic [CW-1:0] ci;
      take = hsel_i && hready_i && htrans_i[1];
      ci = sel_q;
      wr_ph_d = take && hwrite_i;
      rd_ph_d = take && !hwrite_i;
      adr_d = take ? haddr_i[7:0] : adr_q;
      rdata_d = rdata_q;
      wcode_d = wcode_q;
      gap_d = gap_q;
      sel_d = sel_q;
      irq_en_d = irq_en_q;
      need_d = need_q;
      prim_d = prim_q;
      run_d = run_q;
      irq_ev = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         opcode_d[c] = opcode_q[c];
         cfg_d[c] = cfg_q[c];
         node_d[c] = node_q[c];
         param_d[c] = param_q[c];
         err_d[c] = err_q[c];
         type_d[c] = type_q[c];
         count_d[c] = count_q[c];
         prev_d[c] = prev_q[c];
         delta_d[c] = delta_q[c];
         if (opcode_q[c] == OPCODE_OFF) begin
            err_d[c][ERR_OFFLINE] = 1'b1;
         end
         run_d[c] = elig[c];
         if (elig[c] && !run_q[c]) begin
            need_d[c] = 1'b1;
            type_d[c] = TYPE_UNKNOWN;
         end
      end
      st_d = st_q;
      kind_d = kind_q;
      cur_d = cur_q;
      tmr_d = tmr_q;
      ms_d = ms_q;
      // Poll engine
      case (st_q)
         S_PICK: begin
            if (nxt_ok) begin
               cur_d = nxt;
               st_d = S_SEND;
               kind_d = need_q[nxt] ? FBP_Q_SEARCH : FBP_Q_POLL;
            end
         end
         S_SEND: begin
            if (query_ready_i) begin
               st_d = S_WAIT;
               tmr_d = '0;
            end
         end
         S_WAIT: begin
            tmr_d = tmr_q + 32'h1;
            if (reply_valid_i) begin
               err_d[cur_q][ERR_COMM] = 1'b0;
               err_d[cur_q][ERR_OFFLINE] = 1'b0;
               err_d[cur_q] = (err_d[cur_q] & ~ERR_REMOTE_MASK) | (reply_i.status & ERR_REMOTE_MASK);
               st_d = S_GAP;
               case (kind_q)
                  FBP_Q_SEARCH: begin
                     type_d[cur_q] = reply_i.dev_type;
                     count_d[cur_q] = reply_i.sub_count;
                     prim_d[cur_q] = cfg_q[cur_q][CFG_ENERGY];
                     if (cfg_q[cur_q][CFG_PARAMS]) begin
                        kind_d = FBP_Q_PWRITE;
                        st_d = S_SEND;
                     end else begin
                        need_d[cur_q] = 1'b0;
                     end
                  end
                  FBP_Q_PWRITE: begin
                     kind_d = FBP_Q_PREAD;
                     st_d = S_SEND;
                  end
                  FBP_Q_PREAD: begin
                     err_d[cur_q][ERR_PARAM] = (reply_i.value != param_q[cur_q]);
                     need_d[cur_q] = 1'b0;
                  end
                  default: begin
                     if (prim_q[cur_q]) begin
                        prev_d[cur_q] = reply_i.value;
                        prim_d[cur_q] = 1'b0;
                     end else begin
                        delta_d[cur_q] = reply_i.value - prev_q[cur_q];
                     end
                  end
               endcase
               irq_ev[IRQ_DONE] = 1'b1;
               irq_ev[IRQ_FAULT] = |(reply_i.status & ERR_REMOTE_MASK);
            end else if (tmr_q + 32'h1 >= wait_cyc) begin
               err_d[cur_q][ERR_COMM] = 1'b1;
               irq_ev[IRQ_TIMEOUT] = 1'b1;
               st_d = S_GAP;
            end
            if (st_d == S_GAP) begin
               tmr_d = '0;
               ms_d = '0;
            end
         end
         S_GAP: begin
            if (ms_q >= gap_q) begin
               st_d = S_PICK;
            end else if (tmr_q + 32'h1 >= 32'(CYC_PER_MS)) begin
               tmr_d = '0;
               ms_d = ms_q + 16'h1;
            end else begin
               tmr_d = tmr_q + 32'h1;
            end
         end
         default: st_d = S_PICK;
      endcase
      // Register writes
      if (wr_ph_q) begin
         case (adr_q)
            REG_CTRL: wcode_d = hwdata_i[3:0];
            REG_GAP: gap_d = hwdata_i[15:0];
            REG_SEL: sel_d = hwdata_i[CW-1:0];
            REG_CHCFG: begin
               opcode_d[ci] = hwdata_i[2:0];
               cfg_d[ci] = hwdata_i[5:0];
            end
            REG_NODE: begin
               node_d[ci] = hwdata_i;
               if (hwdata_i != node_q[ci]) begin
                  need_d[ci] = 1'b1;
                  type_d[ci] = TYPE_UNKNOWN;
               end
            end
            REG_PARAM: param_d[ci] = hwdata_i;
            REG_REINST: begin
               for (int c = 0; c < NUM_CH; c++) begin
                  if (hwdata_i[REINST_ALL] || (hwdata_i[0] && CW'(c) == ci)) begin
                     need_d[c] = 1'b1;
                     type_d[c] = TYPE_UNKNOWN;
                  end
               end
            end
            REG_IRQ_EN: irq_en_d = hwdata_i[2:0];
            default: ;
         endcase
      end
      irq_st_d = (irq_st_q & ~((wr_ph_q && adr_q == REG_IRQ_CLR) ? hwdata_i[2:0] : 3'h0)) | irq_ev;
      if (rd_ph_d) begin
         case (haddr_i[7:0])
            REG_CTRL: rdata_d = {28'h0, wcode_q};
            REG_GAP: rdata_d = {16'h0, gap_q};
            REG_SEL: rdata_d = 32'(sel_q);
            REG_CHCFG: rdata_d = {26'h0, cfg_q[sel_q][5:3], opcode_q[sel_q]};
            REG_NODE: rdata_d = node_q[sel_q];
            REG_PARAM: rdata_d = param_q[sel_q];
            REG_CHSTAT: rdata_d = {15'h0, need_q[sel_q], count_q[sel_q], type_q[sel_q]};
            REG_ERR: rdata_d = err_q[sel_q];
            REG_DELTA: rdata_d = delta_q[sel_q];
            REG_IRQ_STAT: rdata_d = {29'h0, irq_st_q};
            REG_IRQ_EN: rdata_d = {29'h0, irq_en_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            opcode_q[c] <= OPCODE_OFF;
            cfg_q[c] <= '0;
            node_q[c] <= '0;
            param_q[c] <= '0;
            err_q[c] <= '0;
            type_q[c] <= TYPE_UNKNOWN;
            count_q[c] <= '0;
            prev_q[c] <= '0;
            delta_q[c] <= '0;
         end
         need_q <= '0;
         prim_q <= '0;
         run_q <= '0;
         wcode_q <= WAIT_CODE_RST;
         gap_q <= GAP_MS_RST;
         sel_q <= '0;
         cur_q <= '0;
         irq_st_q <= '0;
         irq_en_q <= '0;
         st_q <= S_PICK;
         kind_q <= FBP_Q_POLL;
         tmr_q <= '0;
         ms_q <= '0;
         wr_ph_q <= 1'b0;
         rd_ph_q <= 1'b0;
         adr_q <= '0;
         rdata_q <= '0;
      end else begin
         opcode_q <= opcode_d;
         cfg_q <= cfg_d;
         node_q <= node_d;
         param_q <= param_d;
         err_q <= err_d;
         type_q <= type_d;
         count_q <= count_d;
         prev_q <= prev_d;
         delta_q <= delta_d;
         need_q <= need_d;
         prim_q <= prim_d;
         run_q <= run_d;
         wcode_q <= wcode_d;
         gap_q <= gap_d;
         sel_q <= sel_d;
         cur_q <= cur_d;
         irq_st_q <= irq_st_d;
         irq_en_q <= irq_en_d;
         st_q <= st_d;
         kind_q <= kind_d;
         tmr_q <= tmr_d;
         ms_q <= ms_d;
         wr_ph_q <= wr_ph_d;
         rd_ph_q <= rd_ph_d;
         adr_q <= adr_d;
         rdata_q <= rdata_d;
      end
   end
endmodule : fbp_poller

// ==== fbp_poller_sva.sv ====
/*
 Checker for the channel poller top ports: bus answer, query handshake, reset.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fbp_poller_sva
   import fbp_pkg::*;
#(
   parameter int unsigned NUM_CH = 64
) (
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // reset
   input wire logic hsel_i, // select
   input wire logic [31:0] haddr_i, // address
   input wire logic [1:0] htrans_i, // transfer
   input wire logic hwrite_i, // write
   input wire logic [2:0] hsize_i, // size
   input wire logic [31:0] hwdata_i, // wdata
   input wire logic hready_i, // ready in
   input wire logic [31:0] hrdata_o, // rdata
   input wire logic hreadyout_o, // ready out
   input wire logic hresp_o, // response
   input wire fbp_query_s query_o, // query
   input wire logic query_valid_o, // query strobe
   input wire logic query_ready_i, // accept
   input wire fbp_reply_s reply_i, // reply
   input wire logic reply_valid_i, // reply strobe
   input wire logic irq_o // interrupt
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic taken_rd;
   assign taken_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   sequence s_accept;
      query_valid_o && query_ready_i;
   endsequence
   sequence s_wait4;
      s_accept ##1 (!reply_valid_i) [*4];
   endsequence
   a_ready_high: assert property (hreadyout_o)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp_o)
      else $error("error response");
   a_query_hold: assert property (query_valid_o && !query_ready_i |=> query_valid_o && $stable(query_o))
      else $error("query changed before acceptance");
   a_accept_drop: assert property (s_accept |=> !query_valid_o)
      else $error("query strobe after acceptance");
   a_wait_quiet: assert property (s_wait4 |-> !query_valid_o)
      else $error("new query while awaiting reply");
   a_reset_quiet: assert property ($fell(sys_rst_i) |-> hrdata_o == 32'h0 && !query_valid_o && !irq_o)
      else $error("outputs active after reset");
   a_rdata_hold: assert property (!taken_rd |=> $stable(hrdata_o))
      else $error("read data moved without read");
   a_chan_range: assert property (query_valid_o |-> query_o.chan < NUM_CH)
      else $error("query to missing channel");
endmodule : fbp_poller_sva

bind fbp_poller fbp_poller_sva #(.NUM_CH(NUM_CH)) fbp_poller_sva_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .query_o(query_o), .query_valid_o(query_valid_o), .query_ready_i(query_ready_i),
   .reply_i(reply_i), .reply_valid_i(reply_valid_i), .irq_o(irq_o));

// ==== fbp_remote_model.sv ====
/*
 Behavioural remote meter set: takes one query at a time, answers later.
 Assumes the poller holds a query until query_ready_o is high.
*/
`timescale 1ns/1ps
module fbp_remote_model
   import fbp_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic sys_rst_i, // reset
   input wire fbp_query_s query_i, // query
   input wire logic query_valid_i, // strobe
   output logic query_ready_o, // accept
   output fbp_reply_s reply_o, // reply
   output logic reply_valid_o, // reply strobe
   input wire logic stall_i, // refuse queries
   input wire logic slow_i, // late answers
   input wire logic bad_param_i, // corrupt read back
   input wire logic [15:0] ident_i, // type and count
   input wire logic [31:0] status_i, // remote faults
   input wire logic [31:0] value_i // meter value
);
   int cnt;
   fbp_query_s held;
   logic [31:0] stored;
   fbp_reply_s r;
   assign query_ready_o = cnt == 0 && !stall_i;
   always @(posedge clk_i) begin
      // Lines toggle between answers so a stale reply never looks valid
      r = ~reply_o;
      reply_valid_o <= 1'b0;
      if (sys_rst_i) begin
         cnt <= 0;
         r = '0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         reply_valid_o <= 1'b1;
         r = {ident_i, status_i, value_i};
         if (held.kind == FBP_Q_PREAD) begin
            r.value = bad_param_i ? ~stored : stored;
         end
      end else if (query_valid_i && query_ready_o) begin
         held <= query_i;
         cnt <= slow_i ? 40 : 3;
         if (query_i.kind == FBP_Q_PWRITE) begin
            stored <= query_i.param;
         end
      end
      reply_o <= r;
   end
endmodule : fbp_remote_model

// ==== test_fbp_poller.sv ====
/*
 Self-checking bench for the channel poller with a remote meter model.
 Assumes a zero-wait AHB-Lite slave and replies well inside the wait time.
*/
`timescale 1ns/1ps
module test_fbp_poller;
   import fbp_pkg::*;
   logic clk_i, sys_rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd, node, status, value, v0;
   logic [1:0] htrans_i;
   logic [2:0] hsize_i;
   logic query_valid_o, query_ready_i, reply_valid_i, stall, slow, bad;
   logic [15:0] ident;
   logic [7:0] last;
   fbp_query_s query_o;
   fbp_reply_s reply_i;
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed = 32'hd14f2efb;
   logic [7:0] qlog[$];
   fbp_poller #(.NUM_CH(4)) fbp_poller_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .query_o(query_o), .query_valid_o(query_valid_o), .query_ready_i(query_ready_i), .reply_i(reply_i),
      .reply_valid_i(reply_valid_i), .irq_o(irq_o));
   fbp_remote_model fbp_remote_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .query_i(query_o),
      .query_valid_i(query_valid_o), .query_ready_o(query_ready_i), .reply_o(reply_i),
      .reply_valid_o(reply_valid_i), .stall_i(stall), .slow_i(slow), .bad_param_i(bad), .ident_i(ident),
      .status_i(status), .value_i(value));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (!sys_rst_i && query_valid_o && query_ready_i) qlog.push_back({query_o.kind, query_o.chan});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic edge_rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (hreadyout_o !== 1'b1 && k < 64);
      if (hreadyout_o !== 1'b1) begin
         n_mismatch++;
         tally_and_finish;
      end
   endtask : edge_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      edge_rdy;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      edge_rdy;
      rd = hrdata_o;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic idle(input int n, input bit rnd);
      repeat (n) begin
         @(posedge clk_i);
         if (rnd) stall <= 1'($random(seed));
      end
      stall <= 1'b0;
   endtask : idle
   function automatic logic [31:0] nq(input logic [7:0] v);
      int c;
      c = 0;
      foreach (qlog[i]) if (qlog[i] == v) c++;
      return 32'(c);
   endfunction : nq
   initial begin
      #2000000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      {hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i} = '0;
      hsel_i = 1'b1;
      hsize_i = 3'h2;
      {stall, slow, bad, status, value} = '0;
      ident = 16'h2103;
      sys_rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdc(REG_CTRL, 32'h9);
      rdc(REG_GAP, 32'h0);
      rdc(REG_CHSTAT, 32'hFF);
      rdc(REG_ERR, 32'h40);
      rdc(8'h3C, 32'h0);
      for (int c = 0; c < 16; c++) begin
         wr(REG_CTRL, c);
         rdc(REG_CTRL, c);
      end
      wr(REG_CTRL, 32'h9);
      $display("reset test done");
      node = $random(seed);
      status <= $random(seed) & ERR_REMOTE_MASK;
      value <= $random(seed);
      wr(REG_SEL, 32'h1);
      wr(REG_NODE, node);
      wr(REG_PARAM, $random(seed));
      qlog.delete();
      wr(REG_CHCFG, 32'h3C);
      idle(300, 1);
      chk(qlog[0], {FBP_Q_SEARCH, 6'h01});
      chk(qlog[1], {FBP_Q_PWRITE, 6'h01});
      chk(qlog[2], {FBP_Q_PREAD, 6'h01});
      chk(qlog[3], {FBP_Q_POLL, 6'h01});
      rdc(REG_CHSTAT, 32'h0321);
      rdc(REG_ERR, status);
      v0 = value;
      value <= v0 + 32'h1234;
      idle(100, 0);
      rdc(REG_DELTA, 32'h1234);
      $display("install test done");
      bad <= 1'b1;
      slow <= 1'b1;
      wr(REG_REINST, 32'h1);
      bus(1'b0, REG_CHSTAT, 32'h0);
      chk(rd & 32'hFF, 32'hFF);
      idle(600, 0);
      rdc(REG_ERR, status | 32'h02000000);
      bad <= 1'b0;
      slow <= 1'b0;
      qlog.delete();
      wr(REG_NODE, node ^ 32'h1);
      wr(REG_NODE, node);
      idle(300, 0);
      chk(32'(nq({FBP_Q_SEARCH, 6'h01}) > 0), 32'h1);
      $display("reinstall test done");
      wr(REG_SEL, 32'h3);
      wr(REG_CHCFG, 32'h0C);
      idle(150, 1);
      qlog.delete();
      idle(300, 1);
      last = 8'hFF;
      chk(32'(qlog.size() > 4), 32'h1);
      foreach (qlog[i]) begin
         if (last != 8'hFF) chk(qlog[i], last[0+:6] == 6'h01 ? 8'h03 : 8'h01);
         last = qlog[i];
      end
      wr(REG_CHCFG, 32'h0);
      idle(20, 0);
      qlog.delete();
      idle(200, 0);
      chk(nq({FBP_Q_POLL, 6'h03}), 32'h0);
      bus(1'b0, REG_ERR, 32'h0);
      chk(rd & 32'h40, 32'h40);
      $display("scan test done");
      stall <= 1'b1;
      repeat (60) @(posedge clk_i);
      wr(REG_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h1);
      wr(REG_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      wr(REG_IRQ_CLR, 32'h7);
      rdc(REG_IRQ_STAT, 32'h0);
      wr(REG_IRQ_EN, 32'h7);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      qlog.delete();
      wr(REG_REINST, 32'h2);
      // The remote side must accept queries again or no reply can raise the interrupt
      stall <= 1'b0;
      idle(300, 0);
      chk({31'h0, irq_o}, 32'h1);
      chk(32'(nq({FBP_Q_SEARCH, 6'h01}) > 0), 32'h1);
      $display("interrupt test done");
      tally_and_finish;
   end
endmodule : test_fbp_poller
